//--- pkg/tmr_pkg.sv
// tmr_pkg: constants, types and register map of the 8-bit single-compare timer
// assumes one 250 MHz system clock and a cpu register port with one-cycle read latency
// Notes on behaviour
// RQ1 - count and compare are cpu readable writable
// RQ2 - bottom at 0x00, max at 0xff
// RQ3 - top is 0xff or compare, per mode
// RQ4 - clock select field zero stops counter
// RQ5 - tick from prescaler or external pin
// RQ6 - each tick clears, increments or decrements
// RQ7 - cpu accesses count at any time
// RQ8 - cpu count write beats clear or count
// RQ9 - waveform mode field sets count sequence
// RQ10 - overflow flag set per mode, requests interrupt
// RQ11 - match whenever count equals compare
// RQ12 - compare flag set on next tick
// RQ13 - compare irq needs flag, enable, global enable
// RQ14 - flag cleared by service or writing one
// RQ15 - output pin from match, mode fields
// RQ16 - max and bottom feed waveform generator
// RQ17 - compare double buffered in pwm modes only
// RQ18 - buffered compare loads at top or bottom
// RQ19 - shared flag and mask registers gate requests
// RQ20 - normal mode overflow sets on wrap, never clears
// RQ21 - mode 2 clears count on compare match
// RQ22 - count write blocks match next tick
// RQ23 - tick arrives as one-cycle clock enable
package tmr_pkg;
    // register addresses on the cpu port
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_COUNT   = 3'h1;
    localparam logic [2:0] ADDR_COMPARE = 3'h2;
    localparam logic [2:0] ADDR_FLAGS   = 3'h3;
    localparam logic [2:0] ADDR_MASK    = 3'h4;

    // control register fields
    localparam int CS_LSB  = 0;
    localparam int WGM_LSB = 3;
    localparam int COM_LSB = 5;
    localparam int FOC_BIT = 7;

    // flag and mask bit positions
    localparam int OVF_BIT = 0;
    localparam int CMP_BIT = 1;

    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_MAX    = 8'hff;
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [2:0] CS_STOPPED   = 3'h0;
    localparam logic [2:0] CS_EXT_FALL  = 3'h6;
    localparam logic [2:0] CS_EXT_RISE  = 3'h7;

    typedef enum logic [1:0] {
        TMR_NORMAL    = 2'b00,
        TMR_PWM_PHASE = 2'b01,
        TMR_CTC       = 2'b10,
        TMR_PWM_FAST  = 2'b11
    } tmr_wave_t;

    typedef enum logic [1:0] {
        TMR_COM_OFF    = 2'b00,
        TMR_COM_TOGGLE = 2'b01,
        TMR_COM_CLEAR  = 2'b10,
        TMR_COM_SET    = 2'b11
    } tmr_com_t;

    // cpu register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tmr_bus_t;

    // tick inputs: one prescaler bit per prescaled rate (select codes 1..5), and the external pin level
    typedef struct packed {
        logic [4:0] presc_tick;
        logic       ext_level;
    } tmr_tick_t;
endpackage : tmr_pkg

//--- src/tmr_core.sv
// tmr_core: 8-bit bidirectional timer with one compare unit and register port
// assumes prescaler ticks are one-cycle pulses and the pin level is synchronous
`timescale 1ns/10ps
module tmr_core (
    // clock and reset
    input  wire logic             mclk_in,
    input  wire logic             reset_in,
    // cpu register port
    input  wire tmr_pkg::tmr_bus_t bus_in,
    output logic [7:0]            rdata_out,
    // tick sources and cpu interrupt side
    input  wire tmr_pkg::tmr_tick_t tick_in,
    input  wire logic             global_irq_enable_in,
    input  wire logic             ovf_ack_in,
    input  wire logic             cmp_ack_in,
    // status and waveform
    output logic                  ovf_irq_out,
    output logic                  cmp_irq_out,
    output logic                  compare_output_pin,
    output logic                  max_out,
    output logic                  bottom_out
);
    import tmr_pkg::*;

    logic [7:0] timer_count_value, next_timer_count_value;
    logic [7:0] compare_value, next_compare_value;
    logic [7:0] compare_buf, next_compare_buf;
    logic [7:0] timer_control_reg, next_timer_control_reg;
    logic       overflow_flag, next_overflow_flag;
    logic       compare_flag, next_compare_flag;
    logic [1:0] timer_mask_reg, next_timer_mask_reg;
    logic       down, next_down;
    logic       block_match, next_block_match;
    logic       pin_q, next_pin_q;
    logic       ext_prev, next_ext_prev;
    logic [7:0] rdata, next_rdata;

    logic [2:0] clock_select_field;
    tmr_wave_t  waveform_mode_field;
    tmr_com_t   compare_output_mode_field;
    logic       timer_tick, match, is_top, pwm, cnt_wr;
    logic       ovf_set, cmp_set;

    // field decode and status indications
    assign clock_select_field        = timer_control_reg[CS_LSB +: 3];
    assign waveform_mode_field       = tmr_wave_t'(timer_control_reg[WGM_LSB +: 2]);  // see RQ9
    assign compare_output_mode_field = tmr_com_t'(timer_control_reg[COM_LSB +: 2]);
    assign pwm        = waveform_mode_field == TMR_PWM_PHASE || waveform_mode_field == TMR_PWM_FAST;
    assign bottom_out = timer_count_value == COUNT_BOTTOM;  // see RQ2 see RQ16
    assign max_out    = timer_count_value == COUNT_MAX;     // see RQ2 see RQ16
    assign is_top     = (waveform_mode_field == TMR_CTC) ? match : max_out;  // see RQ3
    assign match      = timer_count_value == compare_value;  // see RQ11
    assign cnt_wr     = bus_in.wr && bus_in.addr == ADDR_COUNT;
    // hardware set events, these win over any clear in the same cycle
    assign ovf_set    = timer_tick && ((waveform_mode_field == TMR_PWM_PHASE) ? bottom_out : max_out);
    assign cmp_set    = timer_tick && match && !block_match;

    // tick select: prescaler rates or external edge, none when stopped
    always_comb begin
        unique case (clock_select_field)  // see RQ4 see RQ5 see RQ23
            CS_STOPPED:  timer_tick = 1'b0;
            CS_EXT_FALL: timer_tick = ext_prev && !tick_in.ext_level;
            CS_EXT_RISE: timer_tick = !ext_prev && tick_in.ext_level;
            default:     timer_tick = tick_in.presc_tick[clock_select_field - 3'h1];
        endcase
    end

    // interrupt requests gated by mask and global enable
    assign ovf_irq_out = overflow_flag && timer_mask_reg[OVF_BIT] && global_irq_enable_in;  // see RQ10 see RQ19
    assign cmp_irq_out = compare_flag && timer_mask_reg[CMP_BIT] && global_irq_enable_in;   // see RQ13 see RQ19
    assign compare_output_pin = pin_q;
    assign rdata_out = rdata;

    // next-state computation for counter, compare, flags and registers
    always_comb begin
        next_timer_count_value = timer_count_value;
        next_compare_value     = compare_value;
        next_compare_buf       = compare_buf;
        next_timer_control_reg = timer_control_reg;
        next_overflow_flag     = overflow_flag;
        next_compare_flag      = compare_flag;
        next_timer_mask_reg    = timer_mask_reg;
        next_down              = down;
        next_pin_q             = pin_q;
        next_ext_prev          = tick_in.ext_level;
        next_block_match       = block_match;
        next_rdata             = 8'h00;
        if (timer_tick) begin
            next_block_match = 1'b0;  // see RQ22
            unique case (waveform_mode_field)  // see RQ6
                TMR_NORMAL, TMR_PWM_FAST: begin
                    next_timer_count_value = timer_count_value + 8'h01;
                    if (max_out)
                        next_overflow_flag = 1'b1;  // see RQ20
                end
                TMR_CTC: begin
                    if (match)
                        next_timer_count_value = COUNT_BOTTOM;  // see RQ21
                    else
                        next_timer_count_value = timer_count_value + 8'h01;
                    if (max_out)
                        next_overflow_flag = 1'b1;
                end
                TMR_PWM_PHASE: begin
                    if (max_out || (down && !bottom_out)) begin
                        next_down = 1'b1;
                        next_timer_count_value = timer_count_value - 8'h01;
                    end else begin
                        next_down = 1'b0;
                        next_timer_count_value = timer_count_value + 8'h01;
                    end
                    if (bottom_out)
                        next_overflow_flag = 1'b1;
                end
            endcase
            if (match && !block_match) begin
                next_compare_flag = 1'b1;  // see RQ12
                unique case (compare_output_mode_field)  // see RQ15
                    TMR_COM_OFF:    next_pin_q = pin_q;
                    TMR_COM_TOGGLE: next_pin_q = pwm ? pin_q : !pin_q;
                    TMR_COM_CLEAR:  next_pin_q = (waveform_mode_field == TMR_PWM_PHASE && down) ? 1'b1 : 1'b0;
                    TMR_COM_SET:    next_pin_q = (waveform_mode_field == TMR_PWM_PHASE && down) ? 1'b0 : 1'b1;
                endcase
            end
            if (pwm && waveform_mode_field == TMR_PWM_FAST && max_out) begin
                // fast pwm restarts the pulse at the wrap
                if (compare_output_mode_field == TMR_COM_CLEAR)
                    next_pin_q = 1'b1;
                else if (compare_output_mode_field == TMR_COM_SET)
                    next_pin_q = 1'b0;
            end
            if (pwm && ((waveform_mode_field == TMR_PWM_FAST && max_out) ||
                        (waveform_mode_field == TMR_PWM_PHASE && max_out)))
                next_compare_value = compare_buf;  // see RQ18
        end
        // service acknowledges clear flags, a new set wins
        if (ovf_ack_in && !next_overflow_flag)
            next_overflow_flag = 1'b0;
        if (ovf_ack_in && !(timer_tick && max_out && waveform_mode_field != TMR_PWM_PHASE)
            && !(timer_tick && bottom_out && waveform_mode_field == TMR_PWM_PHASE))
            next_overflow_flag = 1'b0;
        if (cmp_ack_in && !(timer_tick && match && !block_match))
            next_compare_flag = 1'b0;  // see RQ14
        // register writes from the cpu
        if (bus_in.wr) begin
            unique case (bus_in.addr)
                ADDR_CONTROL: begin
                    next_timer_control_reg = bus_in.wdata;
                    next_timer_control_reg[FOC_BIT] = 1'b0;
                    if (bus_in.wdata[FOC_BIT] && !pwm && compare_output_mode_field == TMR_COM_TOGGLE)
                        next_pin_q = !pin_q;  // forced match moves only the pin
                    else if (bus_in.wdata[FOC_BIT] && !pwm && compare_output_mode_field == TMR_COM_CLEAR)
                        next_pin_q = 1'b0;
                    else if (bus_in.wdata[FOC_BIT] && !pwm && compare_output_mode_field == TMR_COM_SET)
                        next_pin_q = 1'b1;
                end
                ADDR_COUNT: begin
                    next_timer_count_value = bus_in.wdata;  // see RQ7 see RQ8
                    next_block_match = 1'b1;                // see RQ22
                end
                ADDR_COMPARE: begin
                    next_compare_buf = bus_in.wdata;  // see RQ1
                    if (!pwm)
                        next_compare_value = bus_in.wdata;  // see RQ17
                end
                ADDR_FLAGS: begin
                    if (bus_in.wdata[OVF_BIT] && !ovf_set)
                        next_overflow_flag = 1'b0;
                    if (bus_in.wdata[CMP_BIT] && !cmp_set)
                        next_compare_flag = 1'b0;  // see RQ14
                end
                ADDR_MASK: next_timer_mask_reg = {bus_in.wdata[CMP_BIT], bus_in.wdata[OVF_BIT]};
                default: ;
            endcase
        end
        // read data one cycle later
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                ADDR_CONTROL: next_rdata = timer_control_reg;
                ADDR_COUNT:   next_rdata = timer_count_value;  // see RQ7
                ADDR_COMPARE: next_rdata = pwm ? compare_buf : compare_value;
                ADDR_FLAGS:   next_rdata = {6'h00, compare_flag, overflow_flag};
                ADDR_MASK:    next_rdata = {6'h00, timer_mask_reg};
                default:      next_rdata = 8'h00;
            endcase
        end
    end

    // state registers
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            timer_count_value <= RESET_BYTE;
            compare_value     <= RESET_BYTE;
            compare_buf       <= RESET_BYTE;
            timer_control_reg <= RESET_BYTE;
            overflow_flag     <= 1'b0;
            compare_flag      <= 1'b0;
            timer_mask_reg    <= 2'h0;
            down              <= 1'b0;
            block_match       <= 1'b0;
            pin_q             <= 1'b0;
            ext_prev          <= 1'b0;
            rdata             <= RESET_BYTE;
        end else begin
            timer_count_value <= next_timer_count_value;
            compare_value     <= next_compare_value;
            compare_buf       <= next_compare_buf;
            timer_control_reg <= next_timer_control_reg;
            overflow_flag     <= next_overflow_flag;
            compare_flag      <= next_compare_flag;
            timer_mask_reg    <= next_timer_mask_reg;
            down              <= next_down;
            block_match       <= next_block_match;
            pin_q             <= next_pin_q;
            ext_prev          <= next_ext_prev;
            rdata             <= next_rdata;
        end
    end
endmodule : tmr_core

//--- dv/tmr_core_sva.sv
// tmr_core_sva: port-level checks of the 8-bit timer
// assumes the tmr_pkg register map and a synchronous active-high reset
`timescale 1ns/10ps
module tmr_core_sva (
    // clock, reset and inputs
    input wire logic               mclk_in,
    input wire logic               reset_in,
    input wire tmr_pkg::tmr_bus_t  bus_in,
    input wire tmr_pkg::tmr_tick_t tick_in,
    input wire logic               global_irq_enable_in,
    input wire logic               ovf_ack_in,
    input wire logic               cmp_ack_in,
    // outputs under watch
    input wire logic [7:0]         rdata_out,
    input wire logic               ovf_irq_out,
    input wire logic               cmp_irq_out,
    input wire logic               compare_output_pin,
    input wire logic               max_out,
    input wire logic               bottom_out
);
    import tmr_pkg::*;
    logic ext_d1;
    logic ext_d2;
    logic quiet;
    // pin history, so a quiet cycle is one in which no tick can arrive
    always_ff @(posedge mclk_in) begin
        ext_d1 <= tick_in.ext_level;
        ext_d2 <= ext_d1;
    end
    assign quiet = (tick_in.presc_tick == 5'h00) && (tick_in.ext_level == ext_d1) && (ext_d1 == ext_d2);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    limit_excl_a: assert property (!(max_out && bottom_out))
        else $error("max and bottom high together");
    cnt_write_a: assert property (bus_in.wr && bus_in.addr == ADDR_COUNT |=>
        max_out == ($past(bus_in.wdata) == COUNT_MAX) && bottom_out == ($past(bus_in.wdata) == COUNT_BOTTOM))
        else $error("count write not taken");
    rdata_idle_a: assert property (!bus_in.rd |=> rdata_out == 8'h00)
        else $error("read data without read");
    unmapped_a: assert property (bus_in.rd && bus_in.addr > ADDR_MASK |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    gie_gate_a: assert property (!global_irq_enable_in |-> !ovf_irq_out && !cmp_irq_out)
        else $error("request without global enable");
    cmp_hold_a: assert property (cmp_irq_out && !cmp_ack_in && !bus_in.wr |=> cmp_irq_out || !global_irq_enable_in)
        else $error("compare request dropped alone");
    ovf_hold_a: assert property (ovf_irq_out && !ovf_ack_in && !bus_in.wr |=> ovf_irq_out || !global_irq_enable_in)
        else $error("overflow request dropped alone");
    cmp_clear_a: assert property (quiet && (cmp_ack_in || bus_in.wr && bus_in.addr == ADDR_FLAGS && bus_in.wdata[CMP_BIT])
        |=> !cmp_irq_out) else $error("compare flag not cleared");
    ovf_clear_a: assert property (quiet && (ovf_ack_in || bus_in.wr && bus_in.addr == ADDR_FLAGS && bus_in.wdata[OVF_BIT])
        |=> !ovf_irq_out) else $error("overflow flag not cleared");
    no_tick_a: assert property (quiet && !bus_in.wr |=> $stable(max_out) && $stable(bottom_out))
        else $error("count moved without tick");
endmodule : tmr_core_sva
bind tmr_core tmr_core_sva i_tmr_core_sva (.mclk_in, .reset_in, .bus_in, .tick_in, .global_irq_enable_in,
    .ovf_ack_in, .cmp_ack_in, .rdata_out, .ovf_irq_out, .cmp_irq_out, .compare_output_pin, .max_out, .bottom_out);

//--- dv/tmr_cpu_model.sv
// tmr_cpu_model: cpu side that services one timer interrupt line
// assumes the timer takes the ack as a one-cycle pulse
`timescale 1ns/10ps
module tmr_cpu_model #(
    parameter int DELAY = 0
) (
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic reset_in,
    // service side
    input  wire logic svc_en_in,
    input  wire logic irq_in,
    output logic      ack_out
);
    int wait_cnt;
    // answer a pending request after DELAY cycles with one ack pulse
    always_ff @(posedge mclk_in) begin
        if (reset_in || !svc_en_in || !irq_in || ack_out) begin
            wait_cnt <= 0;
            ack_out  <= 1'b0;
        end else if (wait_cnt >= DELAY) begin
            ack_out <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule : tmr_cpu_model

//--- dv/tb.sv
// tb: directed register-level tests of the 8-bit timer
// assumes the design, the cpu model and the checker bind are compiled first
`timescale 1ns/10ps
module tb;
    import tmr_pkg::*;
    logic       mclk_in, reset_in, gie, svc_en, ovf_ack, cmp_ack, ovf_irq, cmp_irq, pin, max_o, bot_o;
    logic [7:0] rdata;
    tmr_bus_t   bus;
    tmr_tick_t  tick;
    int         error_cnt = 0;
    int         compares = 0;
    tmr_core i_tmr_core (.mclk_in(mclk_in), .reset_in(reset_in), .bus_in(bus), .rdata_out(rdata),
        .tick_in(tick), .global_irq_enable_in(gie), .ovf_ack_in(ovf_ack), .cmp_ack_in(cmp_ack),
        .ovf_irq_out(ovf_irq), .cmp_irq_out(cmp_irq), .compare_output_pin(pin), .max_out(max_o), .bottom_out(bot_o));
    tmr_cpu_model #(.DELAY(0)) i_tmr_cpu_model (.mclk_in(mclk_in), .reset_in(reset_in), .svc_en_in(svc_en),
        .irq_in(ovf_irq), .ack_out(ovf_ack));
    tmr_cpu_model #(.DELAY(3)) i_tmr_cpu_model_cmp (.mclk_in(mclk_in), .reset_in(reset_in), .svc_en_in(svc_en),
        .irq_in(cmp_irq), .ack_out(cmp_ack));
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in);
        bus.wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [2:0] a, input logic [7:0] exp, input string name);
        @(posedge mclk_in);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge mclk_in);
        bus.rd <= 1'b0;
        #1 chk(name, exp, rdata);
    endtask : bus_rd
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge mclk_in);
            tick.presc_tick <= 5'h01;
            @(posedge mclk_in);
            tick.presc_tick <= 5'h00;
        end
    endtask : ticks
    task automatic conclude;
        if (error_cnt == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    // free-running 250 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    // watchdog well beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk_in);
        error_cnt++;
        conclude();
    end
    // directed sequence
    initial begin
        reset_in = 1'b1; bus = '0; tick = '0; gie = 1'b0; svc_en = 1'b0;
        repeat (12) @(posedge mclk_in);
        reset_in <= 1'b0;
        #1 chk("bottom_out", 8'h01, {7'h00, bot_o});
        for (int a = 0; a < 5; a++) bus_rd(a[2:0], 8'h00, "reset value");
        bus_wr(ADDR_COUNT, 8'h5a);
        bus_wr(ADDR_COMPARE, 8'ha5);
        bus_wr(3'h5, 8'hff);
        bus_rd(3'h5, 8'h00, "unmapped");
        bus_rd(ADDR_COMPARE, 8'ha5, "compare");
        ticks(3);
        bus_rd(ADDR_COUNT, 8'h5a, "stopped count");
        bus_wr(ADDR_COUNT, 8'hfe);
        bus_wr(ADDR_CONTROL, 8'h01);
        ticks(1);
        #1 chk("max_out", 8'h01, {7'h00, max_o});
        ticks(1);
        bus_rd(ADDR_FLAGS, 8'h01, "wrap flag");
        bus_wr(ADDR_MASK, 8'h01);
        #1 chk("ovf masked off", 8'h00, {7'h00, ovf_irq});
        @(posedge mclk_in) gie <= 1'b1;
        @(posedge mclk_in) #1 chk("ovf_irq", 8'h01, {7'h00, ovf_irq});
        bus_wr(ADDR_FLAGS, 8'h01);
        #1 chk("ovf cleared", 8'h00, {7'h00, ovf_irq});
        bus_wr(ADDR_COMPARE, 8'h10);
        bus_wr(ADDR_COUNT, 8'h10);
        ticks(1);
        bus_rd(ADDR_FLAGS, 8'h00, "blocked match");
        bus_wr(ADDR_COUNT, 8'h0f);
        ticks(1);
        bus_rd(ADDR_FLAGS, 8'h00, "match early");
        ticks(1);
        bus_rd(ADDR_FLAGS, 8'h02, "match flag");
        bus_wr(ADDR_MASK, 8'h03);
        #1 chk("cmp_irq", 8'h01, {7'h00, cmp_irq});
        @(posedge mclk_in) svc_en <= 1'b1;
        repeat (8) @(posedge mclk_in);
        bus_rd(ADDR_FLAGS, 8'h00, "serviced");
        bus_wr(ADDR_CONTROL, 8'h00);
        bus_wr(ADDR_COUNT, 8'h00);
        bus_wr(ADDR_COMPARE, 8'h03);
        bus_wr(ADDR_CONTROL, 8'h11);
        ticks(3);
        bus_rd(ADDR_COUNT, 8'h03, "ctc top");
        ticks(1);
        bus_rd(ADDR_COUNT, 8'h00, "ctc clear");
        @(posedge mclk_in);
        tick.presc_tick <= 5'h01;
        bus <= '{addr: ADDR_COUNT, wdata: 8'h40, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in);
        tick.presc_tick <= 5'h00;
        bus.wr <= 1'b0;
        bus_rd(ADDR_COUNT, 8'h40, "write priority");
        bus_wr(ADDR_CONTROL, 8'h07);
        repeat (4) begin
            @(posedge mclk_in) tick.ext_level <= ~tick.ext_level;
            repeat (3) @(posedge mclk_in);
        end
        bus_rd(ADDR_COUNT, 8'h42, "pin edges");
        bus_wr(ADDR_CONTROL, 8'h20);
        #1 chk("pin before force", 8'h00, {7'h00, pin});
        bus_wr(ADDR_CONTROL, 8'ha0);
        #1 chk("forced toggle", 8'h01, {7'h00, pin});
        bus_rd(ADDR_CONTROL, 8'h20, "force reads zero");
        conclude();
    end
endmodule : tb
